// ---- src/fnst_pkg.sv ----
// fnst_pkg: constants and types for the connection frame number tracker
// assumes one 100 MHz clock domain; no software-visible registers
package fnst_pkg;

  // counter and field widths
  localparam int unsigned CFN_W    = 8;
  localparam int unsigned SFN_W    = 12;
  localparam int unsigned DOFFF_W  = 10;
  localparam int unsigned DOFFT_W  = 8;
  localparam int unsigned CHIP_W   = 16;
  localparam int unsigned L1CFG_W  = 4;

  // frame arithmetic: chips per frame and chips per default-offset step
  localparam int unsigned CHIPS_PER_FRAME = 38400;
  localparam int unsigned CHIPS_PER_DOFF  = 512;

  // reset values
  localparam logic [CFN_W-1:0]   CFN_RST   = 8'h00;
  localparam logic [CHIP_W-1:0]  CHIP_RST  = 16'h0000;
  localparam logic [L1CFG_W-1:0] L1CFG_RST = 4'h0;

  // tracker states
  typedef enum logic [1:0] {
    FNST_IDLE,
    FNST_RUN,
    FNST_HO_WAIT
  } fnst_state_t;

endpackage : fnst_pkg

// ---- src/fnst_cfn_calc.sv ----
// fnst_cfn_calc: combinational start value of the connection frame number
// assumes sfn and default offsets are stable while the caller samples the result
`timescale 1ns/1ps

module fnst_cfn_calc (
  input  wire logic                         i_fdd_mode,
  input  wire logic [fnst_pkg::SFN_W-1:0]   i_sfn,
  input  wire logic [fnst_pkg::DOFFF_W-1:0] i_default_offset_fdd,
  input  wire logic [fnst_pkg::DOFFT_W-1:0] i_default_offset_tdd,
  output logic      [fnst_pkg::CFN_W-1:0]   o_cfn_init
);

  logic [31:0]                 doff_chips;
  logic [31:0]                 frames_back;
  logic [fnst_pkg::CFN_W-1:0]  sfn_low;

  // floor((sfn*f - d*s)/f) equals sfn - ceil(d*s/f); avoids a wide signed divider
  always_comb begin
    doff_chips  = 32'(i_default_offset_fdd) * 32'(fnst_pkg::CHIPS_PER_DOFF);
    frames_back = (doff_chips + 32'(fnst_pkg::CHIPS_PER_FRAME) - 32'h1)
                  / 32'(fnst_pkg::CHIPS_PER_FRAME);
    sfn_low     = i_sfn[fnst_pkg::CFN_W-1:0];
    if (i_fdd_mode) begin
      o_cfn_init = sfn_low - frames_back[fnst_pkg::CFN_W-1:0];
    end else begin
      o_cfn_init = sfn_low - i_default_offset_tdd;
    end
  end

endmodule : fnst_cfn_calc

// ---- src/fnst_tracker.sv ----
// fnst_tracker: terminal-side connection frame number tracking, offset reports,
// handover correction and frame-synchronised layer-1 configuration switch
// assumes all inputs but i_rst_b synchronous to i_mclk and i_frame_stb one cycle per radio frame
`timescale 1ns/1ps

module fnst_tracker #(
  parameter logic [7:0] OFF_SUBST = 8'hff   // substitute offset when target not measurable
) (
  input  wire logic                          i_mclk,
  input  wire logic                          i_rst_b,
  input  wire logic                          i_ce,
  input  wire logic                          i_frame_stb,
  input  wire logic                          i_fdd_mode,
  input  wire logic                          i_dch_state,
  input  wire logic [fnst_pkg::SFN_W-1:0]    i_ref_sfn,
  input  wire logic [fnst_pkg::DOFFF_W-1:0]  i_default_offset_fdd,
  input  wire logic [fnst_pkg::DOFFT_W-1:0]  i_default_offset_tdd,
  input  wire logic                          i_init_stb,
  input  wire logic                          i_doff_new_stb,
  input  wire logic                          i_ho_stb,
  input  wire logic                          i_tgt_sfn_stb,
  input  wire logic [fnst_pkg::SFN_W-1:0]    i_tgt_sfn,
  input  wire logic                          i_meas_stb,
  input  wire logic                          i_meas_target,
  input  wire logic                          i_meas_ok,
  input  wire logic [fnst_pkg::SFN_W-1:0]    i_meas_sfn,
  input  wire logic [fnst_pkg::CHIP_W-1:0]   i_meas_chip,
  input  wire logic                          i_rpt_request,
  input  wire logic                          i_fdd_to_tdd_ho,
  input  wire logic                          i_switch_stb,
  input  wire logic [fnst_pkg::CFN_W-1:0]    i_switch_cfn,
  input  wire logic [fnst_pkg::L1CFG_W-1:0]  i_switch_cfg,
  output logic      [fnst_pkg::CFN_W-1:0]    o_cfn,
  output logic                               o_cfn_valid,
  output logic                               o_reinit_pending,
  output logic                               o_rpt_stb,
  output logic      [fnst_pkg::CFN_W-1:0]    o_rpt_off,
  output logic      [fnst_pkg::CHIP_W-1:0]   o_rpt_chip,
  output logic                               o_rpt_chip_valid,
  output logic      [fnst_pkg::L1CFG_W-1:0]  o_l1_cfg,
  output logic                               o_l1_switch_stb,
  output logic                               o_switch_armed
);

  logic                               rst_meta_q;
  logic                               rst_sync_q;
  fnst_pkg::fnst_state_t              state_q;
  logic [fnst_pkg::CFN_W-1:0]         cfn_q;
  logic                               pend_q;
  logic [fnst_pkg::DOFFF_W-1:0]       default_offset_fdd_q;
  logic [fnst_pkg::DOFFT_W-1:0]       default_offset_tdd_q;
  logic [fnst_pkg::SFN_W-1:0]         calc_sfn;
  logic [fnst_pkg::CFN_W-1:0]         cfn_init;
  logic                               do_init;
  logic                               do_reinit;
  logic                               rpt_allowed;
  logic [fnst_pkg::CFN_W-1:0]         sfn_diff;
  logic [fnst_pkg::CFN_W-1:0]         sw_cfn_q;
  logic [fnst_pkg::L1CFG_W-1:0]       sw_cfg_q;

  // reset release through two flip-flops; left ungated so reset never waits on i_ce
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // default offsets: a fresh value from reconfiguration replaces the stored one
  always_ff @(posedge i_mclk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      default_offset_fdd_q <= '0;
      default_offset_tdd_q <= '0;
    end else if (i_ce && (i_doff_new_stb || i_init_stb)) begin
      default_offset_fdd_q <= i_default_offset_fdd;
      default_offset_tdd_q <= i_default_offset_tdd;
    end
  end

  // initial load uses live offsets and reference sfn; reinit uses stored ones
  assign calc_sfn  = do_reinit ? i_tgt_sfn : i_ref_sfn;
  assign do_init   = i_init_stb;
  assign do_reinit = (state_q == fnst_pkg::FNST_HO_WAIT) && i_tgt_sfn_stb && !i_init_stb;

  fnst_cfn_calc u_calc (
    .i_fdd_mode (i_fdd_mode),
    .i_sfn      (calc_sfn),
    .i_default_offset_fdd (do_init ? i_default_offset_fdd : default_offset_fdd_q),
    .i_default_offset_tdd (do_init ? i_default_offset_tdd : default_offset_tdd_q),
    .o_cfn_init (cfn_init)
  );

  // pending correction: armed by a new default offset, consumed by reinit
  always_ff @(posedge i_mclk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      pend_q <= 1'b0;
    end else if (i_ce) begin
      if (i_doff_new_stb) begin
        pend_q <= 1'b1;
      end else if (do_reinit || do_init) begin
        pend_q <= 1'b0;
      end
    end
  end

  // tracker state: handover with no new offset stays in run, counter untouched
  always_ff @(posedge i_mclk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      state_q <= fnst_pkg::FNST_IDLE;
    end else if (i_ce) begin
      unique case (state_q)
        fnst_pkg::FNST_IDLE: begin
          if (do_init) begin
            state_q <= fnst_pkg::FNST_RUN;
          end
        end
        fnst_pkg::FNST_RUN: begin
          if (i_ho_stb && (pend_q || i_doff_new_stb)) begin
            state_q <= fnst_pkg::FNST_HO_WAIT;
          end
        end
        fnst_pkg::FNST_HO_WAIT: begin
          if (do_reinit || do_init) begin
            state_q <= fnst_pkg::FNST_RUN;
          end
        end
      endcase
    end
  end

  // the counter: load beats increment; it keeps running during the target wait
  always_ff @(posedge i_mclk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      cfn_q <= fnst_pkg::CFN_RST;
    end else if (i_ce) begin
      if (do_init) begin
        cfn_q <= cfn_init;
      end else if (do_reinit) begin
        cfn_q <= cfn_init;
      end else if (i_frame_stb && state_q != fnst_pkg::FNST_IDLE) begin
        cfn_q <= cfn_q + 8'h01;
      end
    end
  end

  // offset reports: candidate cells in any state but idle, target only when network asks
  assign sfn_diff    = i_meas_sfn[fnst_pkg::CFN_W-1:0] - cfn_q;
  assign rpt_allowed = i_meas_stb && state_q != fnst_pkg::FNST_IDLE &&
                       (!i_meas_target || (i_dch_state && i_rpt_request));

  always_ff @(posedge i_mclk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      o_rpt_stb        <= 1'b0;
      o_rpt_off        <= fnst_pkg::CFN_RST;
      o_rpt_chip       <= fnst_pkg::CHIP_RST;
      o_rpt_chip_valid <= 1'b0;
    end else if (i_ce) begin
      o_rpt_stb <= rpt_allowed;
      if (rpt_allowed) begin
        if (i_meas_ok) begin
          o_rpt_off <= sfn_diff;
        end else begin
          o_rpt_off <= OFF_SUBST;
        end
        o_rpt_chip       <= i_fdd_mode ? i_meas_chip : fnst_pkg::CHIP_RST;
        o_rpt_chip_valid <= i_fdd_mode && !i_fdd_to_tdd_ho;
      end
    end
  end

  // switch point: held until the counter reaches it on a frame boundary
  always_ff @(posedge i_mclk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      sw_cfn_q        <= fnst_pkg::CFN_RST;
      sw_cfg_q        <= fnst_pkg::L1CFG_RST;
      o_switch_armed  <= 1'b0;
      o_l1_cfg        <= fnst_pkg::L1CFG_RST;
      o_l1_switch_stb <= 1'b0;
    end else if (i_ce) begin
      o_l1_switch_stb <= 1'b0;
      if (i_switch_stb) begin
        sw_cfn_q       <= i_switch_cfn;
        sw_cfg_q       <= i_switch_cfg;
        o_switch_armed <= 1'b1;
      end else if (o_switch_armed && i_frame_stb && cfn_q + 8'h01 == sw_cfn_q) begin
        // the frame that now begins carries cfn equal to the switch value
        o_l1_cfg        <= sw_cfg_q;
        o_l1_switch_stb <= 1'b1;
        o_switch_armed  <= 1'b0;
      end
    end
  end

  // status outputs, registered
  always_ff @(posedge i_mclk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      o_cfn            <= fnst_pkg::CFN_RST;
      o_cfn_valid      <= 1'b0;
      o_reinit_pending <= 1'b0;
    end else if (i_ce) begin
      o_cfn            <= cfn_q;
      o_cfn_valid      <= state_q != fnst_pkg::FNST_IDLE;
      o_reinit_pending <= pend_q;
    end
  end

endmodule : fnst_tracker

// ---- tb/fnst_tracker_chk.sv ----
// fnst_tracker_chk: port-level timing checks of the frame number tracker
// assumes i_ce held high by the surroundings while the checks matter
`timescale 1ns/1ps
module fnst_tracker_chk #(
  parameter logic [7:0] OFF_SUBST = 8'hff
) (
  input wire logic                         i_mclk, i_rst_b, i_ce, i_frame_stb, i_fdd_mode,
  input wire logic                         i_dch_state, i_init_stb, i_tgt_sfn_stb, i_meas_stb,
  input wire logic                         i_meas_target, i_meas_ok, i_rpt_request,
  input wire logic                         i_fdd_to_tdd_ho, o_cfn_valid, o_rpt_stb,
  input wire logic                         o_l1_switch_stb, o_rpt_chip_valid,
  input wire logic [fnst_pkg::SFN_W-1:0]   i_ref_sfn,
  input wire logic [fnst_pkg::DOFFT_W-1:0] i_default_offset_tdd,
  input wire logic [fnst_pkg::CFN_W-1:0]   o_cfn, o_rpt_off,
  input wire logic [fnst_pkg::L1CFG_W-1:0] o_l1_cfg
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);
  // a load must beat a coinciding frame strobe and appear two edges on
  a_init_tdd: assert property ((i_ce && i_init_stb && !i_fdd_mode)
    ##1 !(i_init_stb || i_frame_stb || i_tgt_sfn_stb)
    |=> o_cfn == 8'($past(i_ref_sfn, 2) - $past(i_default_offset_tdd, 2))) else $error("cfn load bad");
  a_valid_load: assert property (i_ce && i_init_stb |-> ##2 o_cfn_valid)
    else $error("cfn valid late");
  a_frame_inc: assert property ((i_ce && i_frame_stb && o_cfn_valid && !i_init_stb
    && !i_tgt_sfn_stb) |=> ##1 o_cfn == 8'($past(o_cfn) + 1)) else $error("no increment");
  a_rpt_cause: assert property (o_rpt_stb |-> $past(i_meas_stb))
    else $error("report without measurement");
  a_rpt_subst: assert property ((i_ce && i_meas_stb && i_meas_target && !i_meas_ok
    && i_dch_state && i_rpt_request && o_cfn_valid) |=> o_rpt_stb && o_rpt_off == OFF_SUBST)
    else $error("substitute offset bad");
  a_chip_flag: assert property ((i_ce && i_meas_stb && o_cfn_valid && (!i_meas_target
    || i_dch_state && i_rpt_request)) |=> o_rpt_chip_valid == $past(i_fdd_mode
    && !i_fdd_to_tdd_ho)) else $error("chip valid flag bad");
  a_sw_pulse: assert property (o_l1_switch_stb |-> $past(i_frame_stb) ##1 !o_l1_switch_stb)
    else $error("switch pulse bad");
  a_cfg_hold: assert property ($changed(o_l1_cfg) |-> o_l1_switch_stb)
    else $error("config changed off switch");
endmodule : fnst_tracker_chk

bind fnst_tracker fnst_tracker_chk #(.OFF_SUBST(OFF_SUBST)) u_chk (.*);

// ---- tb/fnst_net_model.sv ----
// fnst_net_model: network side stand-in giving radio frame strobes and
// reconfiguration pulses; assumes the bench drives its inputs at negedge
`timescale 1ns/1ps
module fnst_net_model #(parameter int FRAME_CYC = 10) (
  input  wire logic i_mclk,
  input  wire logic i_run,
  input  wire logic i_send_doff,
  output logic      o_frame_stb,
  output logic      o_doff_new_stb
);
  int cnt = 0;
  initial {o_frame_stb, o_doff_new_stb} = 2'b00;
  // one-cycle frame pulse every FRAME_CYC cycles, silent while stopped
  always @(posedge i_mclk) begin
    cnt <= i_run ? (cnt + 1) % FRAME_CYC : 0;
    o_frame_stb <= i_run && cnt == FRAME_CYC - 1;
    o_doff_new_stb <= i_send_doff;
  end
endmodule : fnst_net_model

// ---- tb/frame_number_sync_tracker_bench.sv ----
// frame_number_sync_tracker_bench: directed tests of the tracker
// assumes fnst_net_model supplies frames and new offset pulses
`timescale 1ns/1ps
module frame_number_sync_tracker_bench;
  logic        clk = 0, rst_b = 0, run = 0, send = 0, fdd = 0, dch = 0, req = 0;
  logic        init = 0, ho = 0, tst = 0, ms = 0, mt = 0, mok = 0, f2t = 0, sw = 0;
  logic        ce = 1;
  wire         l1s;
  int          ns = 0;
  logic [11:0] system_frame_number = 0, tsfn = 0, msfn = 0;
  logic [9:0]  dfd = 0;
  logic [7:0]  dtd = 0, swc = 0;
  logic [3:0]  swg = 0;
  logic [15:0] mch = 0;
  wire         frm, dnew, cv, pend, rs, rcv, arm;
  wire  [7:0]  cfn, roff;
  wire  [15:0] rchip;
  wire  [3:0]  l1;
  int          err_count = 0, n_tests = 0, nf = 0;
  fnst_net_model net (.i_mclk(clk), .i_run(run), .i_send_doff(send), .o_frame_stb(frm),
    .o_doff_new_stb(dnew));
  fnst_tracker uut (
    .i_mclk(clk), .i_rst_b(rst_b), .i_ce(ce), .i_frame_stb(frm), .i_fdd_mode(fdd),
    .i_dch_state(dch), .i_ref_sfn(system_frame_number), .i_default_offset_fdd(dfd), .i_default_offset_tdd(dtd),
    .i_init_stb(init), .i_doff_new_stb(dnew), .i_ho_stb(ho), .i_tgt_sfn_stb(tst),
    .i_tgt_sfn(tsfn), .i_meas_stb(ms), .i_meas_target(mt), .i_meas_ok(mok),
    .i_meas_sfn(msfn), .i_meas_chip(mch), .i_rpt_request(req), .i_fdd_to_tdd_ho(f2t),
    .i_switch_stb(sw), .i_switch_cfn(swc), .i_switch_cfg(swg), .o_cfn(cfn),
    .o_cfn_valid(cv), .o_reinit_pending(pend), .o_rpt_stb(rs), .o_rpt_off(roff),
    .o_rpt_chip(rchip), .o_rpt_chip_valid(rcv), .o_l1_cfg(l1), .o_l1_switch_stb(l1s),
    .o_switch_armed(arm));
  // clock and a count of frames the design has seen
  always #5 clk = ~clk;
  always @(posedge clk) if (frm) nf <= nf + 1;
  // count of layer-1 switch pulses, so a doubled or missing pulse is seen
  always @(posedge clk) if (l1s) ns <= ns + 1;
  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic pulse(ref logic s);
    s = 1;
    cyc(1);
    s = 0;
  endtask : pulse
  task automatic chk(string nm, logic [15:0] got, logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // floor division keeps negative intermediate values correct
  function automatic logic [7:0] fcfn(logic [11:0] s, logic [9:0] d);
    int v;
    v = s * 38400 - d * 512;
    return 8'((v < 0 ? v - 38399 : v) / 38400);
  endfunction : fcfn
  task automatic do_init(logic m, logic [11:0] s, logic [9:0] df, logic [7:0] dt);
    {fdd, system_frame_number, dfd, dtd} = {m, s, df, dt};
    pulse(init);
    cyc(3);
  endtask : do_init
  // start values in both modes, fdd one wrapping below zero
  task automatic t_init;
    do_init(1, 12'h005, 10'h3ff, 8'h00);
    chk("cfn fdd", cfn, fcfn(12'h005, 10'h3ff));
    chk("valid", cv, 1);
    do_init(0, 12'habc, 10'h000, 8'hc0);
    chk("cfn tdd", cfn, 8'hfc);
    $display("done init");
  endtask : t_init
  // counting across the 255 to 0 wrap
  task automatic t_count;
    do_init(0, 12'h2fd, 10'h000, 8'h00);
    nf = 0;
    run = 1;
    cyc(45);
    run = 0;
    cyc(3);
    chk("cfn wrap", cfn, 8'(8'hfd + nf));
    $display("done count");
  endtask : t_count
  // clock enable low: frame strobes must not move the counter
  task automatic t_ce;
    logic [7:0] c;
    c = cfn;
    ce = 0;
    run = 1;
    cyc(15);
    run = 0;
    ce = 1;
    cyc(3);
    chk("frozen cfn", cfn, c);
    $display("done enable");
  endtask : t_ce
  task automatic meas(logic t, logic ok, logic [11:0] s, output logic g);
    {mt, mok, msfn, mch} = {t, ok, s, 16'h1234};
    pulse(ms);
    g = 0;
    repeat (3) begin
      g |= rs;
      cyc(1);
    end
  endtask : meas
  // candidate and target reports in fdd, target reports only in tdd, counter held still
  task automatic t_rpt;
    logic g;
    {fdd, dch, req} = 3'b111;
    meas(0, 1, 12'h345, g);
    chk("cand stb", g, 1);
    chk("cand off", roff, 8'(8'h45 - cfn));
    chk("chip", rchip, 16'h1234);
    chk("chip valid on", rcv, 1);
    meas(1, 1, 12'h810, g);
    chk("tgt off", roff, 8'(8'h10 - cfn));
    meas(1, 0, 12'h810, g);
    chk("subst", roff, 8'hff);
    f2t = 1;
    meas(1, 1, 12'h810, g);
    chk("chip valid", rcv, 0);
    {fdd, f2t} = 2'b00;
    meas(1, 1, 12'h9a0, g);
    chk("tdd off", roff, 8'(8'ha0 - cfn));
    dch = 0;
    meas(1, 1, 12'h9a0, g);
    chk("not dedicated", g, 0);
    {dch, req} = 2'b10;
    meas(1, 1, 12'h9a0, g);
    chk("unrequested", g, 0);
    $display("done reports");
  endtask : t_rpt
  // handover with known offset, then with a new default offset
  task automatic t_ho;
    logic [7:0] c;
    c = cfn;
    tsfn = 12'h777;
    pulse(ho);
    pulse(tst);
    cyc(3);
    chk("known ho", cfn, c);
    {fdd, dfd} = {1'b1, 10'h050};
    pulse(send);
    cyc(3);
    chk("pending", pend, 1);
    pulse(ho);
    tsfn = 12'h123;
    pulse(tst);
    cyc(3);
    chk("reinit cfn", cfn, fcfn(12'h123, 10'h050));
    chk("pending clr", pend, 0);
    $display("done handover");
  endtask : t_ho
  // layer-1 switch two frames ahead
  task automatic t_sw;
    logic [7:0] c;
    c = cfn;
    {swc, swg} = {8'(c + 2), 4'ha};
    pulse(sw);
    chk("armed", arm, 1);
    nf = 0;
    ns = 0;
    run = 1;
    cyc(25);
    run = 0;
    cyc(3);
    chk("frames", nf, 2);
    chk("l1 cfg", l1, 4'ha);
    chk("switch pulses", ns, 1);
    chk("disarmed", arm, 0);
    $display("done switch");
  endtask : t_sw
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    cyc(12);
    rst_b = 1;
    cyc(3);
    t_init();
    t_count();
    t_ce();
    t_rpt();
    t_ho();
    t_sw();
    tally_and_finish();
  end
  // watchdog well beyond the 164 cycles the tests need
  initial begin
    #20us;
    err_count++;
    tally_and_finish();
  end
endmodule : frame_number_sync_tracker_bench
